// ==== rtl/dmabm_defs.svh ====
`ifndef DMABM_DEFS_SVH
`define DMABM_DEFS_SVH

// Register word addresses on the plain register port
`define DMABM_REG_SOURCE 8'h00
`define DMABM_REG_DEST 8'h04
`define DMABM_REG_COUNT_A 8'h08
`define DMABM_REG_BLOCK_COUNT 8'h0C
`define DMABM_REG_TRANSFER_CTRL 8'h10
`define DMABM_REG_CHANNEL_B_CTRL 8'h14
`define DMABM_REG_STATUS 8'h18

// transfer_control fields
`define DMABM_TC_ENABLE 7
`define DMABM_TC_END_IE 6
`define DMABM_TC_WORD 5
`define DMABM_TC_SRC_STEP 4
`define DMABM_TC_SRC_DEC 3
`define DMABM_TC_BURST 2

// channel_b_control fields
`define DMABM_CB_BLOCK 6
`define DMABM_CB_AREA_SRC 5
`define DMABM_CB_DST_STEP 4
`define DMABM_CB_DST_DEC 3
`define DMABM_CB_SRC_HI 2
`define DMABM_CB_SRC_LO 0

// Reset values
`define DMABM_RST_CTRL 8'h00
`define DMABM_RST_ADDR 24'h000000
`define DMABM_RST_COUNT8 8'h00
`define DMABM_RST_COUNT16 16'h0000

// Timing: least gap from pin request to transfer start
`define DMABM_CLK_PERIOD_NS 40
`define DMABM_REQ_GAP_NS 160
`define DMABM_REQ_GAP_CYC ((`DMABM_REQ_GAP_NS + `DMABM_CLK_PERIOD_NS - 1) / `DMABM_CLK_PERIOD_NS)

`endif

// ==== rtl/dmabm_pkg.sv ====
package dmabm_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ARM = 3'h1,
        ST_GRANT = 3'h3,
        ST_DEAD = 3'h2,
        ST_READ = 3'h6,
        ST_WRITE = 3'h7,
        ST_STEP = 3'h5
    } dmabm_state_t;

    typedef enum logic [2:0] {
        SRC_TIMER0 = 3'h0,
        SRC_TIMER1 = 3'h1,
        SRC_TIMER2 = 3'h2,
        SRC_CONV_END = 3'h3,
        SRC_EXT_EDGE = 3'h4,
        SRC_EXT_LEVEL = 3'h5,
        SRC_AUTO = 3'h6,
        SRC_NONE = 3'h7
    } dmabm_source_t;

    typedef struct packed {
        logic [23:0] addr;
        logic read;
        logic write;
        logic word;
        logic [15:0] wdata;
    } dmabm_bus_cmd_t;

endpackage

// ==== rtl/dmabm_req_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module dmabm_req_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Raw asynchronous inputs
    input wire logic [WIDTH-1:0] async_in,
    // Synchronised level and falling-edge pulse
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] fell
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] last;

    // Idle level of an active-low request is high
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            meta <= '1;
            sync <= '1;
            last <= '1;
        end else begin
            meta <= async_in;
            sync <= meta;
            last <= sync;
        end
    end

    assign level = sync;
    assign fell = last & ~sync;

endmodule

`default_nettype wire

// ==== rtl/dmabm_top.sv ====
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dmabm_defs.svh"

// Functional notes
// [R1] Block mode merges channels A and B; one full block per accepted request.
// [R2] Source address from source_address_a, destination from destination_address_b, 24 bits.
// [R3] Source and destination step independently: increment, decrement or hold.
// [R4] Block-area address register returns to its start value after every block.
// [R5] Block-area select bit: 0 picks destination, 1 picks source.
// [R6] Software loads counter and initial size with M (1-255), block count N.
// [R7] A block runs as one burst; block size counter drops per unit.
// [R8] At zero the size counter reloads from initial size; block count drops.
// [R9] Block count still nonzero: go idle and wait for next request.
// [R10] Block count zero: clear channel enable, stop, end interrupt if enabled.
// [R11] Block mode takes timer 0-2 match, conversion end, pin falling edge only.
// [R12] Normal mode takes pin edge, pin level or auto-request, no internal interrupts.
// [R13] Selected internal interrupt is withheld from the processor while enabled.
// [R14] Starting from an interrupt clears its flag; others stay pending.
// [R15] External source forces request pin to input, transfer-end pin to output.
// [R16] Edge sensing moves one unit per falling edge; early edges may be lost.
// [R17] Level sensing transfers while pin low, releasing bus after each unit.
// [R18] Seen request held until one unit moves; transfer-end low in last write.
// [R19] Block mode: each falling edge moves a block; transfer-end low in block's last write.
// [R20] Auto-request starts once enabled and runs until the count completes.
// [R21] Cycle-steal gives the bus back after every unit.
// [R22] Burst keeps the bus; higher-priority request releases it after current unit.
// [R23] End interrupt output is high while enable is 0 and end-interrupt enable 1.
// [R24] At least four cycles from pin request to start; pin unsampled meanwhile.
// [R25] Higher-priority channels are served first; this pair yields to them.
// [R26] Address step is 1 for bytes and 2 for words, in the selected direction.
// [R27] Request pin is synchronised to the clock before detection.
module dmabm_top (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // System bus
    output logic bus_req,
    input wire logic bus_grant,
    input wire logic bus_ack,
    input wire logic [15:0] bus_rdata,
    output dmabm_pkg::dmabm_bus_cmd_t bus_cmd,
    input wire logic higher_pri_req,
    // External request and transfer-end pins
    input wire logic external_request_n,
    output logic external_request_force_in,
    output logic transfer_end_n,
    output logic transfer_end_oe,
    // Peripheral interrupts: timer0, timer1, timer2 match A, conversion end
    input wire logic [3:0] periph_irq,
    output logic [3:0] periph_irq_clear,
    output logic [3:0] periph_irq_to_cpu,
    // Transfer-end interrupt
    output logic end_irq
);

    dmabm_pkg::dmabm_state_t state;
    dmabm_pkg::dmabm_state_t next_state;
    dmabm_pkg::dmabm_source_t source_sel;

    logic [23:0] source_address_a;
    logic [23:0] destination_address_b;
    logic [23:0] area_start;
    logic [7:0] block_size_counter;
    logic [7:0] block_size_initial;
    logic [15:0] block_count;
    logic [7:0] transfer_control;
    logic [7:0] channel_b_control;

    logic channel_enable;
    logic end_interrupt_enable;
    logic word_size;
    logic block_mode;
    logic area_is_source;
    logic [23:0] step;
    logic source_legal;
    logic source_internal;
    logic source_external;
    logic unit_last;
    logic unit_done;
    logic block_done;
    logic all_done;
    logic trigger;
    logic mid_block;
    logic ext_latch;
    logic ext_level;
    logic ext_fell;
    logic [2:0] gap_count;

    assign channel_enable = transfer_control[`DMABM_TC_ENABLE];
    assign end_interrupt_enable = transfer_control[`DMABM_TC_END_IE];
    assign word_size = transfer_control[`DMABM_TC_WORD];
    assign block_mode = channel_b_control[`DMABM_CB_BLOCK];
    assign area_is_source = channel_b_control[`DMABM_CB_AREA_SRC]; // [R5]
    assign source_sel = dmabm_pkg::dmabm_source_t'(
        channel_b_control[`DMABM_CB_SRC_HI:`DMABM_CB_SRC_LO]);
    assign step = word_size ? 24'h000002 : 24'h000001; // [R26]

    assign source_internal = (source_sel == dmabm_pkg::SRC_TIMER0)
        || (source_sel == dmabm_pkg::SRC_TIMER1)
        || (source_sel == dmabm_pkg::SRC_TIMER2)
        || (source_sel == dmabm_pkg::SRC_CONV_END);
    assign source_external = (source_sel == dmabm_pkg::SRC_EXT_EDGE)
        || (source_sel == dmabm_pkg::SRC_EXT_LEVEL);

    // Illegal combinations never start, so a misprogrammed mode stays idle
    always_comb begin
        if (block_mode) begin
            source_legal = source_internal
                || (source_sel == dmabm_pkg::SRC_EXT_EDGE); // [R11]
        end else begin
            source_legal = source_external
                || (source_sel == dmabm_pkg::SRC_AUTO); // [R12]
        end
    end

    // Pin path is synchronised before any edge or level decision
    dmabm_req_sync #(
        .WIDTH(1)
    ) u_req_sync ( // [R27]
        .clock(clock),
        .reset_n(reset_n),
        .async_in(external_request_n),
        .level(ext_level),
        .fell(ext_fell)
    );

    assign external_request_force_in = source_external; // [R15]
    assign transfer_end_oe = source_external; // [R15]

    // Internal interrupts used as a source do not reach the processor while the channel is enabled in block mode
    always_comb begin
        periph_irq_to_cpu = periph_irq;
        if (channel_enable && source_internal && block_mode) begin
            periph_irq_to_cpu[source_sel[1:0]] = 1'b0; // [R13]
        end
    end

    assign end_irq = !channel_enable && end_interrupt_enable; // [R23]

    assign unit_last = block_mode ? (block_size_counter == 8'h01)
        : ({block_size_counter, block_size_initial} == 16'h0001);
    assign unit_done = (state == dmabm_pkg::ST_WRITE) && bus_ack;

    // Start condition, looked at only while idle
    always_comb begin
        trigger = 1'b0;
        if (channel_enable && source_legal && !higher_pri_req) begin // [R25]
            if (mid_block) begin
                trigger = 1'b1;
            end else if (source_internal) begin
                trigger = periph_irq[source_sel[1:0]];
            end else if (source_external) begin
                trigger = ext_latch;
            end else begin
                trigger = 1'b1; // [R20]
            end
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            dmabm_pkg::ST_IDLE: begin
                if (trigger) begin
                    next_state = (source_external && !mid_block)
                        ? dmabm_pkg::ST_ARM : dmabm_pkg::ST_GRANT;
                end
            end
            dmabm_pkg::ST_ARM: begin
                if (gap_count == 3'h0) begin
                    next_state = dmabm_pkg::ST_GRANT; // [R24]
                end
            end
            dmabm_pkg::ST_GRANT: begin
                if (bus_grant) begin
                    next_state = dmabm_pkg::ST_DEAD;
                end
            end
            dmabm_pkg::ST_DEAD: begin
                next_state = dmabm_pkg::ST_READ;
            end
            dmabm_pkg::ST_READ: begin
                if (bus_ack) begin
                    next_state = dmabm_pkg::ST_WRITE;
                end
            end
            dmabm_pkg::ST_WRITE: begin
                if (bus_ack) begin
                    next_state = dmabm_pkg::ST_STEP;
                end
            end
            dmabm_pkg::ST_STEP: begin
                if (all_done || !channel_enable) begin
                    next_state = dmabm_pkg::ST_IDLE; // [R10]
                end else if (block_mode) begin
                    if (block_done || higher_pri_req) begin
                        next_state = dmabm_pkg::ST_IDLE; // [R9] [R22]
                    end else begin
                        next_state = dmabm_pkg::ST_READ; // [R7]
                    end
                end else if (source_sel == dmabm_pkg::SRC_AUTO
                        && transfer_control[`DMABM_TC_BURST] && !higher_pri_req) begin
                    next_state = dmabm_pkg::ST_READ; // [R22]
                end else begin
                    next_state = dmabm_pkg::ST_IDLE; // [R17] [R21]
                end
            end
            default: begin
                next_state = dmabm_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state <= dmabm_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign bus_req = (state == dmabm_pkg::ST_GRANT) || (state == dmabm_pkg::ST_DEAD)
        || (state == dmabm_pkg::ST_READ) || (state == dmabm_pkg::ST_WRITE)
        || (state == dmabm_pkg::ST_STEP);

    // Least gap between a pin request and the start of the transfer
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            gap_count <= 3'h0;
        end else if (state == dmabm_pkg::ST_IDLE) begin
            gap_count <= 3'(`DMABM_REQ_GAP_CYC - 1); // [R24]
        end else if (gap_count != 3'h0) begin
            gap_count <= gap_count - 3'h1;
        end
    end

    // The pin is looked at only while idle and not inside a block, so edges
    // during a transfer are dropped rather than queued
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ext_latch <= 1'b0;
        end else if (unit_done || !channel_enable) begin
            ext_latch <= 1'b0; // [R18]
        end else if (state == dmabm_pkg::ST_IDLE && !mid_block) begin
            if (source_sel == dmabm_pkg::SRC_EXT_EDGE && ext_fell) begin
                ext_latch <= 1'b1; // [R16] [R19]
            end else if (source_sel == dmabm_pkg::SRC_EXT_LEVEL && !ext_level) begin
                ext_latch <= 1'b1; // [R17]
            end
        end
    end

    // A block left early for a higher-priority master resumes without a new request
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            mid_block <= 1'b0;
        end else if (!channel_enable || (state == dmabm_pkg::ST_STEP && block_done)) begin
            mid_block <= 1'b0;
        end else if (state == dmabm_pkg::ST_IDLE && trigger && block_mode) begin
            mid_block <= 1'b1; // [R1]
        end
    end

    // Flag clear pulse for the interrupt that started the transfer
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            periph_irq_clear <= 4'h0;
        end else begin
            periph_irq_clear <= 4'h0;
            if (state == dmabm_pkg::ST_IDLE && trigger && source_internal && !mid_block) begin
                periph_irq_clear[source_sel[1:0]] <= 1'b1; // [R14]
            end
        end
    end

    // Bus command and data path
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            bus_cmd <= '0;
        end else begin
            bus_cmd.read <= 1'b0;
            bus_cmd.write <= 1'b0;
            if (next_state == dmabm_pkg::ST_READ && state != dmabm_pkg::ST_READ) begin
                bus_cmd.addr <= source_address_a; // [R2]
                bus_cmd.read <= 1'b1;
                bus_cmd.word <= word_size;
            end else if (state == dmabm_pkg::ST_READ && bus_ack) begin
                bus_cmd.addr <= destination_address_b; // [R2]
                bus_cmd.write <= 1'b1;
                bus_cmd.wdata <= bus_rdata;
            end else if (state == dmabm_pkg::ST_READ) begin
                bus_cmd.read <= 1'b1;
            end else if (state == dmabm_pkg::ST_WRITE && !bus_ack) begin
                bus_cmd.write <= 1'b1;
            end
        end
    end

    // Transfer-end pin low through the write of the last unit
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            transfer_end_n <= 1'b1;
        end else if (state == dmabm_pkg::ST_READ && bus_ack && unit_last) begin
            transfer_end_n <= 1'b0; // [R18] [R19]
        end else if (state != dmabm_pkg::ST_WRITE || bus_ack) begin
            transfer_end_n <= 1'b1;
        end
    end

    // Completion flags seen by the step state
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            block_done <= 1'b0;
            all_done <= 1'b0;
        end else if (unit_done) begin
            block_done <= block_mode && unit_last;
            all_done <= unit_last && (!block_mode || block_count == 16'h0001);
        end
    end

    // Hardware updates land first; a software write below takes precedence,
    // the enable bit included, so a register write always wins
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            source_address_a <= `DMABM_RST_ADDR;
            destination_address_b <= `DMABM_RST_ADDR;
            area_start <= `DMABM_RST_ADDR;
            block_size_counter <= `DMABM_RST_COUNT8;
            block_size_initial <= `DMABM_RST_COUNT8;
            block_count <= `DMABM_RST_COUNT16;
            transfer_control <= `DMABM_RST_CTRL;
            channel_b_control <= `DMABM_RST_CTRL;
        end else begin
            if (state == dmabm_pkg::ST_IDLE && trigger && block_mode && !mid_block) begin
                area_start <= area_is_source ? source_address_a
                    : destination_address_b; // [R4]
            end
            if (unit_done) begin
                if (transfer_control[`DMABM_TC_SRC_STEP]) begin
                    source_address_a <= transfer_control[`DMABM_TC_SRC_DEC]
                        ? source_address_a - step : source_address_a + step; // [R3]
                end
                if (channel_b_control[`DMABM_CB_DST_STEP]) begin
                    destination_address_b <= channel_b_control[`DMABM_CB_DST_DEC]
                        ? destination_address_b - step
                        : destination_address_b + step; // [R3]
                end
                if (block_mode) begin
                    if (unit_last) begin
                        block_size_counter <= block_size_initial; // [R8]
                        block_count <= block_count - 16'h0001; // [R8]
                        if (area_is_source) begin
                            source_address_a <= area_start; // [R4]
                        end else begin
                            destination_address_b <= area_start; // [R4]
                        end
                        if (block_count == 16'h0001) begin
                            transfer_control[`DMABM_TC_ENABLE] <= 1'b0; // [R10]
                        end
                    end else begin
                        block_size_counter <= block_size_counter - 8'h01; // [R7]
                    end
                end else begin
                    {block_size_counter, block_size_initial} <=
                        {block_size_counter, block_size_initial} - 16'h0001;
                    if (unit_last) begin
                        transfer_control[`DMABM_TC_ENABLE] <= 1'b0;
                    end
                end
            end
            if (reg_write) begin
                if (reg_addr == `DMABM_REG_SOURCE) begin
                    source_address_a <= reg_wdata[23:0];
                end else if (reg_addr == `DMABM_REG_DEST) begin
                    destination_address_b <= reg_wdata[23:0];
                end else if (reg_addr == `DMABM_REG_COUNT_A) begin
                    block_size_counter <= reg_wdata[15:8]; // [R6]
                    block_size_initial <= reg_wdata[7:0];
                end else if (reg_addr == `DMABM_REG_BLOCK_COUNT) begin
                    block_count <= reg_wdata[15:0];
                end else if (reg_addr == `DMABM_REG_TRANSFER_CTRL) begin
                    transfer_control <= reg_wdata[7:0];
                end else if (reg_addr == `DMABM_REG_CHANNEL_B_CTRL) begin
                    channel_b_control <= reg_wdata[7:0];
                end
            end
        end
    end

    // Read data one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_read) begin
            if (reg_addr == `DMABM_REG_SOURCE) begin
                reg_rdata <= {8'h00, source_address_a};
            end else if (reg_addr == `DMABM_REG_DEST) begin
                reg_rdata <= {8'h00, destination_address_b};
            end else if (reg_addr == `DMABM_REG_COUNT_A) begin
                reg_rdata <= {16'h0000, block_size_counter, block_size_initial};
            end else if (reg_addr == `DMABM_REG_BLOCK_COUNT) begin
                reg_rdata <= {16'h0000, block_count};
            end else if (reg_addr == `DMABM_REG_TRANSFER_CTRL) begin
                reg_rdata <= {24'h000000, transfer_control};
            end else if (reg_addr == `DMABM_REG_CHANNEL_B_CTRL) begin
                reg_rdata <= {24'h000000, channel_b_control};
            end else if (reg_addr == `DMABM_REG_STATUS) begin
                reg_rdata <= {24'h000000, state, mid_block, ext_latch, ext_level,
                    end_irq, bus_req};
            end else begin
                reg_rdata <= 32'h00000000;
            end
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule

`default_nettype wire

// ==== tb/dmabm_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

module dmabm_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // System bus
    input wire logic bus_req,
    input wire logic bus_ack,
    input wire dmabm_pkg::dmabm_bus_cmd_t bus_cmd,
    // Pins
    input wire logic external_request_n,
    input wire logic external_request_force_in,
    input wire logic transfer_end_n,
    input wire logic transfer_end_oe,
    // Peripheral interrupts
    input wire logic [3:0] periph_irq,
    input wire logic [3:0] periph_irq_clear,
    input wire logic [3:0] periph_irq_to_cpu
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    rw_excl_a: assert property (!(bus_cmd.read && bus_cmd.write))
        else $error("read and write together");
    read_write_a: assert property (bus_cmd.read && bus_ack |=> bus_cmd.write)
        else $error("no write after read");
    addr_hold_a: assert property (bus_cmd.read && !bus_ack |=> $stable(bus_cmd.addr))
        else $error("read address moved");
    read_start_a: assert property ($rose(bus_cmd.read) |-> $past(bus_req, 2))
        else $error("read without bus");
    transfer_end_n_write_a: assert property (!transfer_end_n |-> bus_cmd.write)
        else $error("transfer end outside write");
    pin_dir_a: assert property (transfer_end_oe == external_request_force_in)
        else $error("pin directions disagree");
    irq_mask_a: assert property ((periph_irq_to_cpu & ~periph_irq) == 4'h0)
        else $error("interrupt passed without flag");
    clr_pulse_a: assert property (|periph_irq_clear |->
        (periph_irq_clear & ~periph_irq) == 4'h0 ##1 periph_irq_clear == 4'h0)
        else $error("bad flag clear");
    req_gap_a: assert property ($fell(external_request_n) && !bus_req |=> !bus_req [*4])
        else $error("pin request too fast");

    cover property (bus_cmd.write && bus_ack);
    cover property ($fell(transfer_end_n));
    cover property (|periph_irq_clear);
endmodule

bind dmabm_top dmabm_checker i_dmabm_checker (.*);

`default_nettype wire

// ==== tb/dmabm_bus_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module dmabm_bus_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // System bus
    input wire logic bus_req,
    input wire dmabm_pkg::dmabm_bus_cmd_t bus_cmd,
    output logic bus_grant,
    output logic bus_ack,
    output logic [15:0] bus_rdata
);
    int wait_cyc = 0;
    int cnt = 0;
    logic [39:0] log_q[$];

    // Grant lags the request by a cycle
    always @(posedge clock) begin
        bus_grant <= bus_req && reset_n;
        bus_ack <= 1'b0;
        // Idle data toggles so a stale capture shows
        bus_rdata <= reset_n ? ~bus_rdata : 16'h0000;
        if (reset_n && (bus_cmd.read || bus_cmd.write) && !bus_ack) begin
            if (cnt >= wait_cyc) begin
                bus_ack <= 1'b1;
                cnt <= 0;
                if (bus_cmd.read) begin
                    bus_rdata <= bus_cmd.addr[15:0] ^ 16'h5A5A;
                end else begin
                    log_q.push_back({bus_cmd.addr, bus_cmd.wdata});
                end
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule

`default_nettype wire

// ==== tb/tb_dmabm_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_dmabm_top;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic bus_req, bus_grant, bus_ack, end_irq;
    logic [15:0] bus_rdata;
    dmabm_pkg::dmabm_bus_cmd_t bus_cmd;
    logic higher_pri_req = 1'b0;
    logic external_request_n = 1'b1;
    logic external_request_force_in, transfer_end_n, transfer_end_oe;
    logic [3:0] periph_irq = 4'h0;
    logic [3:0] periph_irq_clear, periph_irq_to_cpu;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int transfer_end_n_falls = 0;

    always #20 clock = ~clock;

    dmabm_top i_dmabm_top (.*);
    dmabm_bus_model i_dmabm_bus_model (.*);

    // Flag drops on its clear pulse; run limit
    always @(posedge clock) begin
        if (|periph_irq_clear) periph_irq <= periph_irq & ~periph_irq_clear;
        if ($fell(transfer_end_n)) transfer_end_n_falls++;
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask

    task setup(input logic [23:0] s, input logic [23:0] d, input logic [7:0] n,
               input logic [7:0] cb, input logic [7:0] tc);
        wr(8'h00, {8'h00, s});
        wr(8'h04, {8'h00, d});
        wr(8'h08, 32'h0202);
        wr(8'h0C, {24'h0, n});
        wr(8'h14, {24'h0, cb});
        wr(8'h10, {24'h0, tc});
    endtask

    // Wait for n logged writes and bus release
    task wait_wr(input int n);
        repeat (400) if (i_dmabm_bus_model.log_q.size() < n) @(posedge clock);
        repeat (20) if (bus_req !== 1'b0) @(posedge clock);
        chk(i_dmabm_bus_model.log_q.size(), n);
    endtask

    task chk_log(input int i, input logic [23:0] a, input logic [15:0] m, input logic [23:0] s);
        logic [39:0] e;
        e = i_dmabm_bus_model.log_q[i];
        chk({8'h00, e[39:16]}, {8'h00, a});
        chk({16'h0, e[15:0] & m}, {16'h0, (s[15:0] ^ 16'h5A5A) & m});
    endtask

    // Byte blocks of 2 from timer 0, destination area, two blocks then done
    task blk_irq;
        setup(24'h000100, 24'h000200, 8'h02, 8'h50, 8'hD0);
        @(posedge clock) periph_irq <= 4'h1;
        #1 chk(periph_irq_to_cpu, 0);
        wait_wr(2);
        chk_log(0, 24'h000200, 16'h00FF, 24'h000100);
        chk_log(1, 24'h000201, 16'h00FF, 24'h000101);
        chk(periph_irq, 0);
        rd(8'h00, 32'h102);
        rd(8'h04, 32'h200);
        rd(8'h08, 32'h0202);
        rd(8'h0C, 32'h1);
        @(posedge clock) periph_irq <= 4'h1;
        wait_wr(4);
        chk_log(2, 24'h000200, 16'h00FF, 24'h000102);
        rd(8'h0C, 32'h0);
        rd(8'h10, 32'h50);
        chk(end_irq, 1);
        rd(8'h3C, 32'h0);
        @(posedge clock) periph_irq <= 4'h3;
        #1 chk(periph_irq_to_cpu, 3);
    endtask

    // Word block from a pin edge, source area stepping down, slow bus
    task blk_pin;
        int f0;
        @(posedge clock) periph_irq <= 4'h0;
        i_dmabm_bus_model.wait_cyc = 3;
        setup(24'h001000, 24'h003000, 8'h01, 8'h74, 8'hB8);
        #1 chk(external_request_force_in, 1);
        chk(transfer_end_oe, 1);
        f0 = transfer_end_n_falls;
        @(posedge clock) external_request_n <= 1'b0;
        wait_wr(6);
        chk_log(4, 24'h003000, 16'hFFFF, 24'h001000);
        chk_log(5, 24'h003002, 16'hFFFF, 24'h000FFE);
        chk(transfer_end_n_falls - f0, 1);
        rd(8'h00, 32'h1000);
        rd(8'h04, 32'h3004);
        rd(8'h10, 32'h38);
        chk(end_irq, 0);
        @(posedge clock) external_request_n <= 1'b1;
    endtask

    task end_sim;
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        blk_irq();
        blk_pin();
        end_sim();
    end
endmodule

`default_nettype wire
